// ### motion_register_address_field_command_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module motion_register_address_field_command_decoder_tb;
	logic        mclk;
	logic        rst_n;
	logic        spiSclk;
	logic        spiCsN;
	logic        spiMosi;
	logic        spiMiso;
	logic        spiMisoOe;
	logic        misoW;
	logic [4:0]  paramAddr;
	logic [1:0]  paramLen;
	logic        paramWritable;
	logic        wrOk;
	logic [23:0] rdVal;
	logic        paramWrEn;
	logic [23:0] paramWrData;
	logic [15:0] statusWord;
	logic        busyN;
	logic        motorRunning;
	logic [19:0] maxSpeed;
	logic [19:0] minSpeed;
	logic        runStart;
	logic        moveStart;
	logic        goToStart;
	logic        goToDirected;
	logic        cmdDir;
	logic [19:0] speedCmd;
	logic [21:0] posCmd;
	logic        stepModeFlag;
	logic        unk;
	logic        refd;
	logic        othV;
	logic [7:0]  othB;
	logic [23:0] rxAcc;
	int          n[5];
	int          fails;
	int          checks;
	int          cyc;
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// register set seen behind the decoder
	assign paramLen = (paramAddr == 5'h0A || paramAddr == 5'h19) ? 2'h2 :
		(paramAddr == 5'h04) ? 2'h3 : 2'h0;
	assign paramWritable = (paramAddr != 5'h19);
	// released line shows the inverse
	assign misoW = spiMisoOe ? spiMiso : ~spiMiso;
	mpcd_host host (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(misoW));
	mpcd_decoder uut (
		.mclk(mclk), .rst_n(rst_n), .spiSclk(spiSclk), .spiCsN(spiCsN),
		.spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
		.paramAddr(paramAddr), .paramLen(paramLen), .paramWritable(paramWritable),
		.paramWriteAllowed(wrOk), .paramRdData(rdVal), .paramWrEn(paramWrEn),
		.paramWrData(paramWrData), .statusWord(statusWord), .busyN(busyN),
		.motorRunning(motorRunning), .maxSpeed(maxSpeed), .minSpeed(minSpeed),
		.runStart(runStart), .moveStart(moveStart), .goToStart(goToStart),
		.goToDirected(goToDirected), .cmdDir(cmdDir), .speedCmd(speedCmd),
		.posCmd(posCmd), .stepModeFlag(stepModeFlag), .otherCmdValid(othV),
		.otherCmdByte(othB), .unknownCmdFlag(unk), .refusedCmdFlag(refd)
	);
	// strobe counters
	always @(posedge mclk)
	begin
		n[0] += (paramWrEn === 1'b1);
		n[1] += (runStart === 1'b1);
		n[2] += (moveStart === 1'b1);
		n[3] += (goToStart === 1'b1);
		n[4] += (othV === 1'b1);
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chkb(input string s, input logic e, input logic g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic args(input logic [23:0] a, input int k);
		logic [7:0] r;
		rxAcc = 24'h0;
		for (int j = k - 1; j >= 0; j--)
		begin
			host.xfer(a[8*j+:8], r);
			rxAcc = {rxAcc[15:0], r};
		end
		repeat (4) @(posedge mclk);
		#2;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [23:0] a, input int k);
		logic [7:0] r;
		host.xfer(c, r);
		args(a, k);
	endtask
	task automatic flags(input logic u, input logic f);
		chkb("unk", u, unk);
		chkb("refd", f, refd);
		cmd(mpcd_pkg::CMD_STATUS, 24'h0, 2);
		chk("status", 24'(statusWord), rxAcc);
		chkb("unkclr", 1'b0, unk);
		chkb("refclr", 1'b0, refd);
	endtask
	task automatic t_wr();
		wrOk = 1'b1;
		cmd(8'h0A, 24'h001234, 2);
		chk("wrN", 24'h1, 24'(n[0]));
		chk("wrData", 24'h001234, paramWrData);
		flags(1'b0, 1'b0);
		wrOk = 1'b0;
		cmd(8'h04, 24'h654321, 3);
		chk("wrN", 24'h1, 24'(n[0]));
		flags(1'b0, 1'b1);
		$display("done wr");
	endtask
	task automatic t_bad();
		cmd(8'h19, 24'h0, 0);
		chk("wrN", 24'h1, 24'(n[0]));
		flags(1'b1, 1'b0);
		cmd(8'h1B, 24'h0, 0);
		flags(1'b1, 1'b0);
		cmd(8'h3B, 24'h0, 0);
		flags(1'b1, 1'b0);
		$display("done bad");
	endtask
	task automatic t_rd();
		logic [7:0] r;
		rdVal = 24'h00ABCD;
		host.xfer(8'h2A, r);
		@(posedge mclk);
		#2;
		rdVal = 24'h005555;
		args(24'h0, 3);
		chk("rd", 24'hABCD00, rxAcc);
		rdVal = 24'h00ABCD;
		cmd(8'h2A, 24'h0, 1);
		chk("rd1", 24'h0000AB, rxAcc);
		rdVal = 24'h123456;
		cmd(8'h24, 24'h0, 3);
		chk("abort", 24'h123456, rxAcc);
		$display("done rd");
	endtask
	task automatic t_run();
		motorRunning = 1'b1;
		busyN = 1'b0;
		cmd(8'h51, 24'hFFFFFF, 3);
		chk("runN", 24'h1, 24'(n[1]));
		chk("spdMax", 24'(maxSpeed), 24'(speedCmd));
		chkb("dir1", 1'b1, cmdDir);
		cmd(8'h50, 24'hF00010, 3);
		chk("spdMin", 24'(minSpeed), 24'(speedCmd));
		chkb("dir0", 1'b0, cmdDir);
		cmd(8'h51, 24'h012345, 3);
		chk("spd", 24'h012345, 24'(speedCmd));
		chk("runN", 24'h3, 24'(n[1]));
		flags(1'b0, 1'b0);
		$display("done run");
	endtask
	task automatic t_step();
		cmd(8'h59, 24'h0, 0);
		chkb("stepRun", 1'b0, stepModeFlag);
		flags(1'b0, 1'b1);
		motorRunning = 1'b0;
		cmd(8'h59, 24'h0, 0);
		chkb("step", 1'b1, stepModeFlag);
		chkb("dir1", 1'b1, cmdDir);
		cmd(8'h58, 24'h0, 0);
		chkb("stepKeep", 1'b1, stepModeFlag);
		chkb("dir0", 1'b0, cmdDir);
		cmd(8'h41, 24'hC00123, 3);
		chk("mvN", 24'h1, 24'(n[2]));
		chk("steps", 24'h000123, 24'(posCmd));
		chkb("dir1", 1'b1, cmdDir);
		chkb("stepEnd", 1'b0, stepModeFlag);
		motorRunning = 1'b1;
		cmd(8'h40, 24'h000010, 3);
		chk("mvN", 24'h1, 24'(n[2]));
		flags(1'b0, 1'b1);
		$display("done step");
	endtask
	task automatic t_absolute_move_cmd();
		busyN = 1'b1;
		cmd(8'h60, 24'h3ABCDE, 3);
		chk("gtN", 24'h1, 24'(n[3]));
		chk("pos", 24'h3ABCDE, 24'(posCmd));
		chkb("undir", 1'b0, goToDirected);
		cmd(8'h69, 24'hC00055, 3);
		chk("gtN", 24'h2, 24'(n[3]));
		chkb("dirGo", 1'b1, goToDirected);
		chkb("dir1", 1'b1, cmdDir);
		busyN = 1'b0;
		cmd(8'h60, 24'h000001, 3);
		flags(1'b0, 1'b1);
		cmd(8'h69, 24'h000001, 3);
		chk("gtN", 24'h2, 24'(n[3]));
		flags(1'b0, 1'b1);
		$display("done absolute_move_cmd");
	endtask
	task automatic t_other();
		motorRunning = 1'b0;
		cmd(8'h59, 24'h0, 0);
		cmd(8'hA8, 24'h0, 0);
		chkb("stepHiz", 1'b1, stepModeFlag);
		chk("othB", 24'h0000A8, 24'(othB));
		cmd(8'h93, 24'h0, 0);
		chkb("stepRel", 1'b0, stepModeFlag);
		chkb("dirRel", 1'b1, cmdDir);
		cmd(8'h82, 24'hFFFFFF, 3);
		chk("untilSpd", 24'(maxSpeed), 24'(speedCmd));
		chkb("dirUntil", 1'b0, cmdDir);
		chk("othB", 24'h000082, 24'(othB));
		chk("othN", 24'h3, 24'(n[4]));
		cmd(8'hE8, 24'h0, 0);
		flags(1'b1, 1'b0);
		$display("done other");
	endtask
	initial
	begin
		rst_n = 1'b0;
		wrOk = 1'b1;
		rdVal = 24'h0;
		statusWord = 16'hC35A;
		busyN = 1'b1;
		motorRunning = 1'b0;
		maxSpeed = 20'h80000;
		minSpeed = 20'h00100;
		repeat (6) @(posedge mclk);
		#2;
		rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#2;
		t_wr();
		t_bad();
		t_rd();
		t_run();
		t_step();
		t_absolute_move_cmd();
		t_other();
		stop_test();
	end
endmodule
`default_nettype wire

// ### mpcd_byte_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mpcd_byte_if;
	logic [7:0] rxByte;
	logic       rxValid;
	logic [7:0] txByte;
	logic       txTake;
	modport link (output rxByte, output rxValid, output txTake, input txByte);
	modport core (input rxByte, input rxValid, input txTake, output txByte);
endinterface
`default_nettype wire

// ### mpcd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module mpcd_decoder (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic                          spiSclk,
	input  wire logic                          spiCsN,
	input  wire logic                          spiMosi,
	output logic                               spiMiso,
	output logic                               spiMisoOe,
	output logic [4:0]                         paramAddr,
	input  wire logic [1:0]                    paramLen,
	input  wire logic                          paramWritable,
	input  wire logic                          paramWriteAllowed,
	input  wire logic [mpcd_pkg::REGISTER_ADDRESS_FIELD_W-1:0]  paramRdData,
	output logic                               paramWrEn,
	output logic [mpcd_pkg::REGISTER_ADDRESS_FIELD_W-1:0]       paramWrData,
	input  wire logic [mpcd_pkg::STATUS_W-1:0] statusWord,
	input  wire logic                          busyN,
	input  wire logic                          motorRunning,
	input  wire logic [mpcd_pkg::SPEED_W-1:0]  maxSpeed,
	input  wire logic [mpcd_pkg::SPEED_W-1:0]  minSpeed,
	output logic                               runStart,
	output logic                               moveStart,
	output logic                               goToStart,
	output logic                               goToDirected,
	output logic                               cmdDir,
	output logic [mpcd_pkg::SPEED_W-1:0]       speedCmd,
	output logic [mpcd_pkg::POS_W-1:0]         posCmd,
	output logic                               stepModeFlag,
	output logic                               otherCmdValid,
	output logic [7:0]                         otherCmdByte,
	output logic                               unknownCmdFlag,
	output logic                               refusedCmdFlag
);
	mpcd_byte_if bif ();

	mpcd_spi_byte u_link (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.spiSclk   (spiSclk),
		.spiCsN    (spiCsN),
		.spiMosi   (spiMosi),
		.spiMiso   (spiMiso),
		.spiMisoOe (spiMisoOe),
		.bif       (bif)
	);

	mpcd_pkg::mpcd_state_e          state_r;
	mpcd_pkg::mpcd_state_e          state_nxt;
	logic [7:0]                     cmdByte_r;
	logic [1:0]                     argLeft_r;
	logic [1:0]                     argLeft_nxt;
	logic [15:0]                    argBuf_r;
	logic [23:0]                    argFull;
	logic [23:0]                    respBuf_r;
	logic [1:0]                     respCnt_r;
	logic                           loadResp;
	logic [23:0]                    respData;
	logic [1:0]                     respLen;
	logic                           isNop;
	logic                           isWrite;
	logic                           isRead;
	logic                           isRun;
	logic                           isStep;
	logic                           isMove;
	logic                           isGoTo;
	logic                           isGoToDir;
	logic                           isStatus;
	logic                           isGoUntil;
	logic                           isRelease;
	logic                           isPlain;
	logic                           isMotionPlain;
	logic                           lastArg;
	logic                           unknownSet;
	logic                           refusedSet;
	logic                           flagClear;
	logic                           stepEnter;
	logic                           stepLeave;
	logic                           wrExec;
	logic                           runExec;
	logic                           moveExec;
	logic                           goExec;
	logic                           otherExec;
	logic [mpcd_pkg::SPEED_W-1:0]   speedClamped;

	// command classification
	always_comb
	begin
		isNop = cmdByte_r == mpcd_pkg::CMD_NOP;
		isWrite = cmdByte_r[7:5] == mpcd_pkg::TOP_WRITE && !isNop;
		isRead = cmdByte_r[7:5] == mpcd_pkg::TOP_READ;
		isRun = (cmdByte_r & mpcd_pkg::DIR_CLR_MASK) == mpcd_pkg::CMD_RUN;
		isStep = (cmdByte_r & mpcd_pkg::DIR_CLR_MASK) == mpcd_pkg::CMD_STEP;
		isMove = (cmdByte_r & mpcd_pkg::DIR_CLR_MASK) == mpcd_pkg::CMD_MOVE;
		isGoTo = cmdByte_r == mpcd_pkg::CMD_ABSOLUTE_MOVE_CMD;
		isGoToDir = (cmdByte_r & mpcd_pkg::DIR_CLR_MASK) == mpcd_pkg::CMD_DIRECTED_ABSOLUTE_MOVE_CMD;
		isStatus = cmdByte_r == mpcd_pkg::CMD_STATUS;
		isGoUntil = (cmdByte_r & mpcd_pkg::SWITCH_MASK) == mpcd_pkg::CMD_GO_UNTIL;
		isRelease = (cmdByte_r & mpcd_pkg::SWITCH_MASK) == mpcd_pkg::CMD_RELEASE;
		isMotionPlain = isRelease || cmdByte_r == mpcd_pkg::CMD_GO_HOME
			|| cmdByte_r == mpcd_pkg::CMD_GO_MARK;
		isPlain = isMotionPlain || cmdByte_r == mpcd_pkg::CMD_RESET_POS
			|| cmdByte_r == mpcd_pkg::CMD_RESET_DEV || cmdByte_r == mpcd_pkg::CMD_SOFT_STOP
			|| cmdByte_r == mpcd_pkg::CMD_HARD_STOP || cmdByte_r == mpcd_pkg::CMD_SOFT_HIZ
			|| cmdByte_r == mpcd_pkg::CMD_HARD_HIZ;
	end

	assign lastArg = state_r == mpcd_pkg::S_ARG && bif.rxValid && argLeft_r == 2'h1;
	assign argFull = {argBuf_r, bif.rxByte};

	// speed clamp to the configured window
	always_comb
	begin
		speedClamped = argFull[mpcd_pkg::SPEED_W-1:0];
		if (speedClamped > maxSpeed)
		begin
			speedClamped = maxSpeed;
		end
		else if (speedClamped < minSpeed)
		begin
			speedClamped = minSpeed;
		end
	end

	// decode and execution decisions
	always_comb
	begin
		state_nxt = state_r;
		argLeft_nxt = argLeft_r;
		loadResp = 1'b0;
		respData = 24'h000000;
		respLen = mpcd_pkg::LEN_NONE;
		unknownSet = 1'b0;
		refusedSet = 1'b0;
		flagClear = 1'b0;
		stepEnter = 1'b0;
		stepLeave = 1'b0;
		wrExec = 1'b0;
		runExec = 1'b0;
		moveExec = 1'b0;
		goExec = 1'b0;
		otherExec = 1'b0;
		unique case (state_r)
			mpcd_pkg::S_CMD:
			begin
				if (bif.rxValid)
				begin
					state_nxt = mpcd_pkg::S_DECODE;
				end
			end
			mpcd_pkg::S_DECODE:
			begin
				state_nxt = mpcd_pkg::S_CMD;
				if (isNop)
				begin
					state_nxt = mpcd_pkg::S_CMD;
				end
				else if (isWrite)
				begin
					if (paramLen == mpcd_pkg::LEN_NONE || !paramWritable)
					begin
						unknownSet = 1'b1;
					end
					else
					begin
						state_nxt = mpcd_pkg::S_ARG;
						argLeft_nxt = paramLen;
					end
				end
				else if (isRead)
				begin
					if (paramLen == mpcd_pkg::LEN_NONE)
					begin
						unknownSet = 1'b1;
					end
					else
					begin
						loadResp = 1'b1;
						respData = paramRdData << (5'h18 - {paramLen, 3'h0});
						respLen = paramLen;
					end
				end
				else if (isStatus)
				begin
					loadResp = 1'b1;
					respData = {statusWord, 8'h00};
					respLen = mpcd_pkg::STATUS_BYTES;
					flagClear = 1'b1;
				end
				else if (isStep)
				begin
					if (motorRunning)
					begin
						refusedSet = 1'b1;
					end
					else
					begin
						stepEnter = 1'b1;
					end
				end
				else if (isRun || isMove || isGoTo || isGoToDir || isGoUntil)
				begin
					state_nxt = mpcd_pkg::S_ARG;
					argLeft_nxt = mpcd_pkg::ARG_BYTES;
				end
				else if (isPlain)
				begin
					otherExec = 1'b1;
					stepLeave = isMotionPlain;
				end
				else
				begin
					unknownSet = 1'b1;
				end
			end
			mpcd_pkg::S_ARG:
			begin
				if (bif.rxValid)
				begin
					argLeft_nxt = argLeft_r - 2'h1;
				end
				if (lastArg)
				begin
					state_nxt = mpcd_pkg::S_CMD;
					if (isWrite)
					begin
						wrExec = paramWriteAllowed;
						refusedSet = !paramWriteAllowed;
					end
					else if (isRun)
					begin
						runExec = 1'b1;
						stepLeave = 1'b1;
					end
					else if (isMove)
					begin
						moveExec = !motorRunning;
						refusedSet = motorRunning;
						stepLeave = !motorRunning;
					end
					else if (isGoTo || isGoToDir)
					begin
						goExec = busyN;
						refusedSet = !busyN;
						stepLeave = busyN;
					end
					else
					begin
						otherExec = 1'b1;
						stepLeave = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= mpcd_pkg::S_CMD;
			argLeft_r <= 2'h0;
			argBuf_r <= 16'h0000;
			cmdByte_r <= 8'h00;
			paramAddr <= 5'h00;
		end
		else
		begin
			state_r <= state_nxt;
			argLeft_r <= argLeft_nxt;
			if (state_r == mpcd_pkg::S_CMD && bif.rxValid)
			begin
				cmdByte_r <= bif.rxByte;
				paramAddr <= bif.rxByte[4:0];
			end
			if (state_r == mpcd_pkg::S_DECODE)
			begin
				argBuf_r <= 16'h0000;
			end
			else if (state_r == mpcd_pkg::S_ARG && bif.rxValid)
			begin
				argBuf_r <= argFull[15:0];
			end
		end
	end

	// answer buffer, abandoned when a newer answer is loaded
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			respBuf_r <= 24'h000000;
			respCnt_r <= 2'h0;
		end
		else if (loadResp)
		begin
			respBuf_r <= respData;
			respCnt_r <= respLen;
		end
		else if (bif.txTake && respCnt_r != 2'h0)
		begin
			respBuf_r <= {respBuf_r[15:0], 8'h00};
			respCnt_r <= respCnt_r - 2'h1;
		end
	end

	assign bif.txByte = (respCnt_r != 2'h0) ? respBuf_r[23:16] : 8'h00;

	// command strobes and arguments to the motion core
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			paramWrEn <= 1'b0;
			paramWrData <= 24'h000000;
			runStart <= 1'b0;
			moveStart <= 1'b0;
			goToStart <= 1'b0;
			goToDirected <= 1'b0;
			cmdDir <= 1'b0;
			speedCmd <= 20'h00000;
			posCmd <= 22'h000000;
			otherCmdValid <= 1'b0;
			otherCmdByte <= 8'h00;
		end
		else
		begin
			paramWrEn <= wrExec;
			runStart <= runExec;
			moveStart <= moveExec;
			goToStart <= goExec;
			otherCmdValid <= otherExec;
			if (wrExec)
			begin
				paramWrData <= argFull;
			end
			if (runExec || (otherExec && isGoUntil))
			begin
				speedCmd <= speedClamped;
			end
			if (moveExec || goExec)
			begin
				posCmd <= argFull[mpcd_pkg::POS_W-1:0];
				goToDirected <= isGoToDir;
			end
			if (runExec || moveExec || stepEnter || (goExec && isGoToDir) || otherExec)
			begin
				cmdDir <= cmdByte_r[0];
			end
			if (otherExec)
			begin
				otherCmdByte <= cmdByte_r;
			end
		end
	end

	// step-input mode, left only by motion commands
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stepModeFlag <= 1'b0;
		end
		else if (stepEnter)
		begin
			stepModeFlag <= 1'b1;
		end
		else if (stepLeave)
		begin
			stepModeFlag <= 1'b0;
		end
	end

	// sticky error flags, a set beats the clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			unknownCmdFlag <= 1'b0;
			refusedCmdFlag <= 1'b0;
		end
		else
		begin
			unknownCmdFlag <= unknownSet || (unknownCmdFlag && !flagClear);
			refusedCmdFlag <= refusedSet || (refusedCmdFlag && !flagClear);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence sRunLast;
		lastArg && isRun;
	endsequence
	sequence sStartPulse;
		runStart ##1 !runStart;
	endsequence
	sequence sReadDecode;
		state_r == mpcd_pkg::S_DECODE && isRead && paramLen == 2'h3;
	endsequence

	a_run_one_pulse: assert property (sRunLast |=> sStartPulse)
		else $error("run start not a single pulse");
	a_run_clamped: assert property (runStart && $past(minSpeed) <= $past(maxSpeed)
		|-> speedCmd <= $past(maxSpeed) && speedCmd >= $past(minSpeed))
		else $error("run speed outside window");
	a_run_leaves_step: assert property (runStart |-> !stepModeFlag)
		else $error("step mode kept after run");
	a_read_msb_first: assert property (sReadDecode |=> bif.txByte == $past(paramRdData[23:16])
		&& respCnt_r == 2'h3)
		else $error("read answer not msb first");
	a_zero_default: assert property (respCnt_r == 2'h0 |-> bif.txByte == 8'h00)
		else $error("nonzero byte without answer");
	a_missing_read: assert property (state_r == mpcd_pkg::S_DECODE && isRead
		&& paramLen == 2'h0 |=> unknownCmdFlag && respCnt_r == $past(respCnt_r))
		else $error("missing register read not flagged");
	a_write_refused: assert property (lastArg && isWrite && !paramWriteAllowed
		|=> refusedCmdFlag && !paramWrEn)
		else $error("refused write not flagged");
	a_absolute_move_cmd_refused: assert property (lastArg && (isGoTo || isGoToDir) && !busyN
		|=> !goToStart && refusedCmdFlag)
		else $error("absolute move taken while busy");
	a_step_refused: assert property (state_r == mpcd_pkg::S_DECODE && isStep && motorRunning
		|=> refusedCmdFlag && stepModeFlag == $past(stepModeFlag))
		else $error("step mode entered while running");
	a_move_refused: assert property (lastArg && isMove && motorRunning
		|=> !moveStart ##1 !moveStart)
		else $error("move taken while running");
endmodule
`default_nettype wire

// ### mpcd_host.sv
`timescale 1ns/1ns
`default_nettype none
module mpcd_host (
	output logic     spiSclk,
	output logic     spiCsN,
	output logic     spiMosi,
	input  wire logic spiMiso
);
	initial
	begin
		spiSclk = 1'b1;
		spiCsN = 1'b1;
		spiMosi = 1'b1;
	end
	// one byte per frame, msb first both ways, sclk idles high
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		spiCsN = 1'b0;
		#230;
		for (int i = 7; i >= 0; i--)
		begin
			spiSclk = 1'b0;
			spiMosi = tx[i];
			#200;
			spiSclk = 1'b1;
			rx[i] = spiMiso;
			#200;
		end
		#200;
		spiCsN = 1'b1;
		spiMosi = ~spiMosi;
		#430;
	endtask
endmodule
`default_nettype wire

// ### mpcd_pkg.sv
`default_nettype none
package mpcd_pkg;
	localparam int SPEED_W = 20;
	localparam int POS_W = 22;
	localparam int STATUS_W = 16;
	localparam int REGISTER_ADDRESS_FIELD_W = 24;
	localparam logic [2:0] TOP_WRITE = 3'h0;
	localparam logic [2:0] TOP_READ = 3'h1;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_RUN = 8'h50;
	localparam logic [7:0] CMD_STEP = 8'h58;
	localparam logic [7:0] CMD_MOVE = 8'h40;
	localparam logic [7:0] CMD_ABSOLUTE_MOVE_CMD = 8'h60;
	localparam logic [7:0] CMD_DIRECTED_ABSOLUTE_MOVE_CMD = 8'h68;
	localparam logic [7:0] CMD_STATUS = 8'hD0;
	localparam logic [7:0] CMD_GO_HOME = 8'h70;
	localparam logic [7:0] CMD_GO_MARK = 8'h78;
	localparam logic [7:0] CMD_RESET_POS = 8'hD8;
	localparam logic [7:0] CMD_RESET_DEV = 8'hC0;
	localparam logic [7:0] CMD_SOFT_STOP = 8'hB0;
	localparam logic [7:0] CMD_HARD_STOP = 8'hB8;
	localparam logic [7:0] CMD_SOFT_HIZ = 8'hA0;
	localparam logic [7:0] CMD_HARD_HIZ = 8'hA8;
	localparam logic [7:0] SWITCH_MASK = 8'hF6;
	localparam logic [7:0] CMD_GO_UNTIL = 8'h82;
	localparam logic [7:0] CMD_RELEASE = 8'h92;
	localparam logic [7:0] DIR_CLR_MASK = 8'hFE;
	localparam logic [1:0] ARG_BYTES = 2'h3;
	localparam logic [1:0] STATUS_BYTES = 2'h2;
	localparam logic [1:0] LEN_NONE = 2'h0;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [2:0] {
		S_CMD    = 3'h1,
		S_DECODE = 3'h2,
		S_ARG    = 3'h4
	} mpcd_state_e;
endpackage
`default_nettype wire

// ### mpcd_spi_byte.sv
`timescale 1ns/1ns
`default_nettype none
module mpcd_spi_byte (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	input  wire logic  spiSclk,
	input  wire logic  spiCsN,
	input  wire logic  spiMosi,
	output logic       spiMiso,
	output logic       spiMisoOe,
	mpcd_byte_if.link  bif
);
	logic [2:0] sclkSync;
	logic [2:0] csSync;
	logic [1:0] mosiSync;
	logic [7:0] txReg_r;
	logic [7:0] rxReg_r;
	logic [2:0] bitCnt_r;
	logic       sclkRise;
	logic       sclkFall;
	logic       csFall;
	logic       inFrame;

	// two-stage synchronisers, third stage only for edge finding
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclkSync <= 3'h7;
			csSync <= 3'h7;
			mosiSync <= 2'h0;
		end
		else
		begin
			sclkSync <= {sclkSync[1:0], spiSclk};
			csSync <= {csSync[1:0], spiCsN};
			mosiSync <= {mosiSync[0], spiMosi};
		end
	end

	assign inFrame = !csSync[1];
	assign csFall = csSync[2] && !csSync[1];
	assign sclkRise = inFrame && !sclkSync[2] && sclkSync[1];
	assign sclkFall = inFrame && sclkSync[2] && !sclkSync[1];

	// shift out on falling edges, sample on rising edges
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txReg_r <= 8'h00;
			rxReg_r <= 8'h00;
			bitCnt_r <= 3'h0;
			spiMiso <= 1'b0;
			spiMisoOe <= 1'b0;
			bif.rxByte <= 8'h00;
			bif.rxValid <= 1'b0;
			bif.txTake <= 1'b0;
		end
		else
		begin
			spiMisoOe <= inFrame;
			bif.rxValid <= 1'b0;
			bif.txTake <= 1'b0;
			if (csFall)
			begin
				txReg_r <= bif.txByte;
				spiMiso <= bif.txByte[7];
				bitCnt_r <= 3'h0;
				bif.txTake <= 1'b1;
			end
			else if (sclkFall)
			begin
				spiMiso <= txReg_r[3'(mpcd_pkg::LAST_BIT - bitCnt_r)];
			end
			else if (sclkRise)
			begin
				rxReg_r <= {rxReg_r[6:0], mosiSync[1]};
				bitCnt_r <= bitCnt_r + 3'h1;
				if (bitCnt_r == mpcd_pkg::LAST_BIT)
				begin
					bif.rxByte <= {rxReg_r[6:0], mosiSync[1]};
					bif.rxValid <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_oe_follows_cs: assert property (csFall |=> spiMisoOe [*2])
		else $error("miso enable not raised in frame");
	a_take_on_frame: assert property (csFall |=> bif.txTake ##1 !bif.txTake)
		else $error("tx byte not taken once per frame");
endmodule
`default_nettype wire
